// ==== include/hpp_pkg.sv ====
// Purpose: shared constants and types for the host parallel port
// Assumes: 125 MHz system clock, byte-wide register space behind the port
// Notes:   times are kept in ns, cycle counts derived from the clock rate
package hpp_pkg;
    localparam int unsigned CLK_PERIOD_NS  = 8;
    localparam int unsigned ACK_MAX_NS     = 150;
    localparam int unsigned ACK_MAX_CYC    = ACK_MAX_NS / CLK_PERIOD_NS;
    localparam int unsigned HOST_CLK_MIN_NS = 20;
    localparam int unsigned ADDR_W         = 11;
    localparam int unsigned REG_ADDR_W     = 8;
    localparam int unsigned DEV_SEL_W      = 3;
    localparam int unsigned DEV_SEL_LSB    = 8;
    localparam int unsigned DATA_W         = 8;
    localparam int unsigned MODE_W         = 3;
    localparam int unsigned REG_DEPTH      = 256;
    localparam logic [2:0]  MODE_ASYNC     = 3'h0;
    localparam logic [7:0]  REG_RESET_VAL  = 8'h00;
    localparam logic [2:0]  DEV_SEL_RESET  = 3'h0;
    localparam logic [10:0] ADDR_RESET     = 11'h000;
    localparam logic [7:0]  DATA_RESET     = 8'h00;

    typedef enum logic [2:0] {
        HPP_IDLE  = 3'b000,
        HPP_READ  = 3'b001,
        HPP_WRITE = 3'b010,
        HPP_DONE  = 3'b011,
        HPP_WAIT  = 3'b100
    } hpp_state_e;
endpackage

// ==== include/hpp_mem_if.sv ====
// Purpose: register storage access between port logic and memory
// Assumes: single clock, one access per cycle
// Notes:   read data valid one cycle after rd_en
`timescale 1ns/1ps
interface hpp_mem_if;
    import hpp_pkg::*;
    logic                  rd_en;
    logic                  wr_en;
    logic [REG_ADDR_W-1:0] addr;
    logic [DATA_W-1:0]     wdata;
    logic [DATA_W-1:0]     rdata;
    modport port (output rd_en, output wr_en, output addr, output wdata, input rdata);
    modport mem  (input rd_en, input wr_en, input addr, input wdata, output rdata);
endinterface

// ==== hdl/hpp_reg_mem.sv ====
// Purpose: 256 x 8 register storage with registered read data
// Assumes: write and read in the same cycle return the old contents
// Notes:   contents are not reset; only the read register is
`timescale 1ns/1ps
module hpp_reg_mem
    import hpp_pkg::*;
(
    input  wire logic sys_clk_i,
    input  wire logic resetn_i,
    hpp_mem_if.mem    mem
);
    logic [DATA_W-1:0] store [REG_DEPTH];
    logic [DATA_W-1:0] rdata_reg;

    // storage array, no reset so it maps onto ram
    always_ff @(posedge sys_clk_i) begin
        if (mem.wr_en) begin
            store[mem.addr] <= mem.wdata;
        end
    end

    // read register
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata_reg <= REG_RESET_VAL;
        end else if (mem.rd_en) begin
            rdata_reg <= store[mem.addr];
        end
    end

    assign mem.rdata = rdata_reg;
endmodule

// ==== hdl/hpp_host_port.sv ====
// Purpose: byte-wide host port, asynchronous or host-clocked handshake
// Assumes: all pins asynchronous to sys_clk_i, host clock period >= 20 ns
// Notes:   every pin passes a two-stage synchroniser before use
`timescale 1ns/1ps
module hpp_host_port
    import hpp_pkg::*;
(
    input  wire logic                 sys_clk_i,
    input  wire logic                 resetn_i,
    input  wire logic [MODE_W-1:0]    host_mode_select_i,
    input  wire logic [DEV_SEL_W-1:0] dev_select_i,
    input  wire logic [ADDR_W-1:0]    addr_i,
    input  wire logic                 chip_sel_n_i,
    input  wire logic                 address_latch_strobe_pin_i,
    input  wire logic                 rd_strobe_n_i,
    input  wire logic                 wr_dir_i,
    input  wire logic [DATA_W-1:0]    data_i,
    output logic      [DATA_W-1:0]    data_o,
    output logic                      data_oe_o,
    output logic                      cycle_done_pin_n_o
);
    // pin bundle order in the synchroniser
    localparam int unsigned PIN_W = ADDR_W + DATA_W + 4 + DEV_SEL_W + MODE_W;

    // state bundle
    //   sync1/sync2  two-stage synchroniser for every pin, only sync2 is read
    //   strobe_d     last synced strobe level, for the falling-edge test
    //   state        cycle sequencer
    //   addr_lat     address captured while the latch strobe is high with chip select low
    //   rdata        byte presented on the data pins during a read
    //   oe           data driver enable, high only while a read answer stands
    //   done_n       ready / acknowledge level, active low
    //   is_read      direction of the cycle in flight
    // timing from a pin strobe fall: two edges of synchroniser, one to
    // decode, one for the storage read, one to register the answer, so
    // ready falls about five clocks (40 ns) later, well inside 150 ns.
    // limitation: the host clock of the synchronous style is not used;
    // its pins are oversampled by the system clock, which is why the
    // host clock period must stay at or above 20 ns.

    typedef struct packed {
        logic [PIN_W-1:0]     sync1;
        logic [PIN_W-1:0]     sync2;
        logic                 strobe_d;
        hpp_state_e           state;
        logic [ADDR_W-1:0]    addr_lat;
        logic [DATA_W-1:0]    rdata;
        logic                 oe;
        logic                 done_n;
        logic                 is_read;
    } hpp_state_s;

    hpp_state_s st_reg;
    hpp_state_s st_next;

    hpp_mem_if mem_bus ();

    hpp_reg_mem u_mem (
        .sys_clk_i (sys_clk_i),
        .resetn_i  (resetn_i),
        .mem       (mem_bus)
    );

    // decode helper: selected device field matches the board strap
    function automatic logic dev_hit(input logic [ADDR_W-1:0] a,
                                     input logic [DEV_SEL_W-1:0] sel);
        dev_hit = (a[DEV_SEL_LSB +: DEV_SEL_W] == sel);
    endfunction

    // read or write request: host-clocked style reads the direction pin,
    // asynchronous style only reaches here through the read strobe
    function automatic logic rd_wanted(input logic sync_style,
                                       input logic dir);
        rd_wanted = sync_style ? dir : 1'b1;
    endfunction

    // refusal: a cycle whose device field differs from the strap, or one
    // without chip select, never leaves idle, so no output moves at all.
    // a shared bus of several ports relies on this, since only one of
    // them may drive the data pins or pull ready low.

    logic [ADDR_W-1:0]    s_addr;
    logic [DATA_W-1:0]    s_data;
    logic                 s_cs_n;
    logic                 s_ale;
    logic                 s_strobe_n;
    logic                 s_dir;
    logic [DEV_SEL_W-1:0] s_dev;
    logic [MODE_W-1:0]    s_mode;
    logic                 sync_mode;
    logic                 strobe_fall;
    logic [ADDR_W-1:0]    cyc_addr;

    // only the second stage is read
    assign {s_addr, s_data, s_cs_n, s_ale, s_strobe_n, s_dir, s_dev, s_mode} = st_reg.sync2;
    assign sync_mode   = (s_mode != MODE_ASYNC);
    assign strobe_fall = st_reg.strobe_d && !s_strobe_n && !s_cs_n;
    // latch held high means transparent address path
    assign cyc_addr    = s_ale ? s_addr : st_reg.addr_lat;

    // next-state logic for the whole port
    always_comb begin
        st_next          = st_reg;
        st_next.sync1    = {addr_i, data_i, chip_sel_n_i, address_latch_strobe_pin_i,
                            rd_strobe_n_i, wr_dir_i, dev_select_i, host_mode_select_i};
        st_next.sync2    = st_reg.sync1;
        st_next.strobe_d = s_strobe_n;
        mem_bus.rd_en    = 1'b0;
        mem_bus.wr_en    = 1'b0;
        mem_bus.addr     = cyc_addr[REG_ADDR_W-1:0];
        mem_bus.wdata    = s_data;

        // address follows the pins while the latch strobe is high and chip select low; fall freezes it
        if (s_ale && !s_cs_n) begin
            st_next.addr_lat = s_addr;
        end

        case (st_reg.state)
            HPP_IDLE: begin
                // a falling shared or read strobe opens a cycle for this device
                if (strobe_fall && dev_hit(cyc_addr, s_dev)) begin
                    // sync mode: direction pin; async mode: read strobe vs write strobe
                    st_next.is_read = rd_wanted(sync_mode, s_dir);
                    if (rd_wanted(sync_mode, s_dir)) begin
                        // start the storage read now, data lands one edge later
                        mem_bus.rd_en = 1'b1;
                        st_next.state = HPP_READ;
                    end else begin
                        st_next.state = HPP_WRITE;
                    end
                end
                // asynchronous write strobe arrives on the direction pin, active low;
                // a level test suffices as the cycle only ends once it is high again
                if (!sync_mode && !s_dir && !s_cs_n && s_strobe_n
                    && dev_hit(cyc_addr, s_dev)) begin
                    st_next.is_read = 1'b0;
                    st_next.state   = HPP_WRITE;
                end
            end
            HPP_READ: begin
                // memory data is registered, one cycle to arrive; drivers wait
                // for valid data so the host never sees a stale byte
                st_next.state = HPP_DONE;
            end
            HPP_WRITE: begin
                mem_bus.wr_en = 1'b1;
                st_next.state = HPP_DONE;
            end
            HPP_DONE: begin
                // data and driver enable rise together with ready
                if (st_reg.is_read) begin
                    st_next.rdata = mem_bus.rdata;
                    st_next.oe    = 1'b1;
                end
                st_next.done_n = 1'b0;
                st_next.state  = HPP_WAIT;
            end
            HPP_WAIT: begin
                // strobe high (both strobes in the asynchronous style) or chip select gone ends the cycle;
                // release is seen through the synchroniser, so ready and
                // the drivers let go about three clocks after the pin rises,
                // and a new strobe before that is simply not yet seen
                if (s_cs_n || (s_strobe_n && (sync_mode || s_dir))) begin
                    st_next.done_n = 1'b1;
                    st_next.oe     = 1'b0;
                    st_next.state  = HPP_IDLE;
                end
            end
            default: begin
                st_next.state = HPP_IDLE;
            end
        endcase
    end

    // single state register; synchroniser resets to all ones, the idle level of chip select and the strobes,
    // so no false strobe edge is seen right after reset
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_reg          <= '0;
            st_reg.sync1    <= '1;
            st_reg.sync2    <= '1;
            st_reg.strobe_d <= 1'b1;
            st_reg.state    <= HPP_IDLE;
            st_reg.addr_lat <= ADDR_RESET;
            st_reg.rdata    <= DATA_RESET;
            st_reg.done_n   <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign data_o             = st_reg.rdata;
    assign data_oe_o          = st_reg.oe;
    assign cycle_done_pin_n_o = st_reg.done_n;
endmodule

// ==== testbench/hpp_port_assertions.sv ====
// Purpose: pin timing checks on the host port
// Assumes: answers within 18 clocks (150 ns)
// Notes:   refusal and release windows kept short
`timescale 1ns/1ps
module hpp_port_assertions
    import hpp_pkg::*;
(
    input wire logic                 sys_clk_i,
    input wire logic                 resetn_i,
    input wire logic [MODE_W-1:0]    host_mode_select_i,
    input wire logic [DEV_SEL_W-1:0] dev_select_i,
    input wire logic [ADDR_W-1:0]    addr_i,
    input wire logic                 chip_sel_n_i,
    input wire logic                 address_latch_strobe_pin_i,
    input wire logic                 rd_strobe_n_i,
    input wire logic                 wr_dir_i,
    input wire logic                 data_oe_o,
    input wire logic                 cycle_done_pin_n_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);
    logic sel_ok;
    logic asy;
    // a request aimed at this device, style from mode select
    assign sel_ok = !chip_sel_n_i && addr_i[10:8] == dev_select_i;
    assign asy    = host_mode_select_i == MODE_ASYNC;
    sequence s_rd;
        $fell(rd_strobe_n_i) && sel_ok && asy && wr_dir_i;
    endsequence
    sequence s_wr;
        $fell(wr_dir_i) && sel_ok && asy && rd_strobe_n_i;
    endsequence
    sequence s_ack;
        ##[1:18] !cycle_done_pin_n_o;
    endsequence
    a_rd_ready: assert property (s_rd |-> s_ack)
        else $error("late read ready");
    a_rd_drives: assert property (s_rd |-> ##[1:18] data_oe_o)
        else $error("read bus not driven");
    a_wr_ready: assert property (s_wr |-> s_ack)
        else $error("late write ready");
    a_wr_quiet: assert property (s_wr |-> !data_oe_o [*8])
        else $error("bus driven on write");
    a_sync_ack: assert property ($fell(rd_strobe_n_i) && sel_ok && !asy |-> s_ack)
        else $error("late acknowledge");
    a_foreign_ignored: assert property
        ((address_latch_strobe_pin_i && addr_i[10:8] != dev_select_i) [*8] |-> cycle_done_pin_n_o)
        else $error("foreign address answered");
    a_cs_release: assert property (chip_sel_n_i [*6] |-> cycle_done_pin_n_o && !data_oe_o)
        else $error("held past deselect");
    a_strobe_release: assert property
        ((rd_strobe_n_i && wr_dir_i) [*6] |-> cycle_done_pin_n_o && !data_oe_o)
        else $error("held past strobe");
endmodule

// ==== testbench/hpp_host_model.sv ====
// Purpose: host processor model on the port pins
// Assumes: one transfer at a time
// Notes:   a released data bus shows its inverse
`timescale 1ns/1ps
module hpp_host_model
    import hpp_pkg::*;
(
    input  wire logic              sys_clk_i,
    input  wire logic              done_n_i,
    input  wire logic [DATA_W-1:0] rdata_i,
    output logic      [MODE_W-1:0] mode_o,
    output logic      [ADDR_W-1:0] addr_o,
    output logic                   cs_n_o,
    output logic                   latch_o,
    output logic                   strobe_n_o,
    output logic                   dir_o,
    output logic      [DATA_W-1:0] wdata_o
);
    // idle: deselected, latch transparent, strobes high
    initial begin
        {mode_o, addr_o, cs_n_o, latch_o, strobe_n_o, dir_o, wdata_o} = {14'h0, 4'hF, 8'h5A};
    end
    // one byte; ok stays low when no answer comes in 40 clocks
    task automatic xfer(input logic [2:0] md, input logic lat, input logic sel,
        input logic [10:0] a, input logic rd, input logic [7:0] wd,
        output logic [7:0] rq, output logic ok);
        int n;
        @(posedge sys_clk_i);
        mode_o <= md;
        addr_o <= a;
        cs_n_o <= ~sel;
        wdata_o <= rd ? ~wdata_o : wd;
        repeat (3) @(posedge sys_clk_i);
        if (lat) begin
            latch_o <= 1'b0;
            repeat (4) @(posedge sys_clk_i);
            addr_o <= ~a;
        end
        dir_o <= (md == MODE_ASYNC) ? 1'b1 : rd;
        @(posedge sys_clk_i);
        if (md != MODE_ASYNC || rd) strobe_n_o <= 1'b0;
        else dir_o <= 1'b0;
        n = 0;
        while (done_n_i !== 1'b0 && n < 40) begin
            @(posedge sys_clk_i);
            n++;
        end
        ok = n < 40;
        rq = rdata_i;
        strobe_n_o <= 1'b1;
        dir_o <= 1'b1;
        wdata_o <= ~wdata_o;
        while (done_n_i !== 1'b1 && n < 80) begin
            @(posedge sys_clk_i);
            n++;
        end
        cs_n_o <= 1'b1;
        latch_o <= 1'b1;
    endtask
endmodule

// ==== testbench/testbench.sv ====
// Purpose: self-checking bench for the host port
// Assumes: host model drives the pins
// Notes:   each row writes a byte, then reads it back
`timescale 1ns/1ps
bind hpp_host_port hpp_port_assertions u_chk (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
    .host_mode_select_i(host_mode_select_i), .dev_select_i(dev_select_i), .addr_i(addr_i),
    .chip_sel_n_i(chip_sel_n_i), .address_latch_strobe_pin_i(address_latch_strobe_pin_i),
    .rd_strobe_n_i(rd_strobe_n_i), .wr_dir_i(wr_dir_i), .data_oe_o(data_oe_o),
    .cycle_done_pin_n_o(cycle_done_pin_n_o));
module testbench;
    import hpp_pkg::*;
    typedef struct packed {logic [2:0] md; logic lat; logic [7:0] ra; logic [7:0] d;} hpp_row_s;
    logic              sys_clk_i = 1'b0;
    logic              resetn_i  = 1'b0;
    logic [2:0]        dev_sel   = 3'h5;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata, rdata, rq;
    logic [MODE_W-1:0] mode;
    logic              cs_n, latch, strobe_n, dir, oe, done_n, ok;
    hpp_row_s          r;
    int                failures = 0;
    int                samples_checked = 0;
    int                cycles = 0;
    // every mode once, then mode 0 again; odd rows and the last row latch then move the pins away
    hpp_row_s rows [9] = '{'{3'h0, 1'b0, 8'h00, 8'h3C}, '{3'h1, 1'b1, 8'hFF, 8'hA5},
        '{3'h2, 1'b0, 8'h7E, 8'h01}, '{3'h3, 1'b1, 8'h81, 8'hFE}, '{3'h4, 1'b0, 8'h10, 8'h5A},
        '{3'h5, 1'b1, 8'hEF, 8'hC3}, '{3'h6, 1'b0, 8'h55, 8'h80}, '{3'h7, 1'b1, 8'hAA, 8'h7F},
        '{3'h0, 1'b1, 8'h33, 8'h96}};
    always #4 sys_clk_i = ~sys_clk_i;
    hpp_host_port dut (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .host_mode_select_i(mode),
        .dev_select_i(dev_sel), .addr_i(addr), .chip_sel_n_i(cs_n), .address_latch_strobe_pin_i(latch),
        .rd_strobe_n_i(strobe_n), .wr_dir_i(dir), .data_i(wdata), .data_o(rdata),
        .data_oe_o(oe), .cycle_done_pin_n_o(done_n));
    hpp_host_model host (.sys_clk_i(sys_clk_i), .done_n_i(done_n), .rdata_i(rdata),
        .mode_o(mode), .addr_o(addr), .cs_n_o(cs_n), .latch_o(latch), .strobe_n_o(strobe_n),
        .dir_o(dir), .wdata_o(wdata));
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // hang guard, far above the roughly 450 clocks needed
    always @(posedge sys_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            failures++;
            finish_test();
        end
    end
    initial begin
        repeat (10) @(posedge sys_clk_i);
        check({6'h0, oe, done_n}, 8'h01);
        resetn_i <= 1'b1;
        repeat (3) @(posedge sys_clk_i);
        foreach (rows[i]) begin
            r = rows[i];
            host.xfer(r.md, r.lat, 1'b1, {dev_sel, r.ra}, 1'b0, r.d, rq, ok);
            check({7'h0, ok}, 8'h01);
            host.xfer(r.md, r.lat, 1'b1, {dev_sel, r.ra}, 1'b1, 8'h00, rq, ok);
            check(rq, r.d);
        end
        // foreign device field, then chip select off: both ignored
        host.xfer(3'h0, 1'b0, 1'b1, {~dev_sel, 8'h00}, 1'b0, 8'hC3, rq, ok);
        check({7'h0, ok}, 8'h00);
        host.xfer(3'h2, 1'b0, 1'b0, {dev_sel, 8'hFF}, 1'b0, 8'hC3, rq, ok);
        check({7'h0, ok}, 8'h00);
        host.xfer(3'h0, 1'b0, 1'b1, {dev_sel, 8'h00}, 1'b1, 8'h00, rq, ok);
        check(rq, rows[0].d);
        host.xfer(3'h2, 1'b0, 1'b1, {dev_sel, 8'hFF}, 1'b1, 8'h00, rq, ok);
        check(rq, rows[1].d);
        // reset after the last transfer keeps the outputs released
        resetn_i <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
        check({6'h0, oe, done_n}, 8'h01);
        finish_test();
    end
endmodule
